// *** hw/csu_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// - Drive doubled system clock source select outward
// - Relaxation trim 0-1023, resets to midpoint
// - Three status flags, software clears any combination
// - External halving changes only when crystal unselected
// - Direct clock mode bit selects pin clocking
// - Lock edge mode changes only while disabled, or to disabled
// - Source readback shows syncing code while switching
// - Lock detector enable gates lock and flags
// - High or low power crystal drive bit
// - Crystal ready only when started and enabled
// - Status flags readable, nonzero when set
// - RC retrim field 0-511 drives oscillator
// - External source select, direct or crystal
// - Clock check resets counters, self clears done
// - Loss trip point 1-15, recommended two
// - Pre and postscaler powers of two to 256
// - PWM clock raw PLL or halved
// - Clock monitor enable feeds loss-of-clock flag
module csu_ctrl #(
	parameter logic [15:0] CHK_REF_LEN = 16'h0100,
	parameter logic [7:0]  MON_DIV     = 8'h64
) (
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic [1:0]            lock_raw,
	input  wire logic                  crystal_ok_raw,
	input  wire logic                  ref_clk_raw,
	input  wire logic                  crystal_clk_raw,
	output logic      [1:0]            sys_clk_x2_sel,
	output logic      [1:0]            prescaler_source_select,
	output csu_pkg::csu_pll_cfg_t      pll_cfg,
	output csu_pkg::csu_osc_cfg_t      osc_cfg,
	output logic                       irq
);

	csu_pkg::csu_state_t st_q;
	csu_pkg::csu_state_t st_d;
	logic [1:0]          lock_ind;
	logic [1:0]          lock_rise;
	logic [1:0]          lock_fall;
	logic [1:0]          lock_evt;
	logic                crystal_ready;
	logic [1:0]          src_read;
	logic                wr_ctrl;
	logic                wr_div;
	logic                wr_stat;
	logic                wr_osc;
	logic                wr_osc2;
	logic                wr_chk;
	logic                ref_edge;
	logic                tgt_edge;
	logic                mon_tick;
	logic                loc_evt;
	logic                rd_stat;

	////////////////////////////////////////////////////////////////////////////
	// Derived status
	assign lock_ind      = st_q.lk_s & {2{st_q.pll.lock_det_en}};
	assign lock_rise     = lock_ind & ~st_q.lk_p;
	assign lock_fall     = ~lock_ind & st_q.lk_p & {2{st_q.pll.lock_det_en}};
	assign crystal_ready = st_q.rdy_s & ~st_q.osc.crystal_pd;
	assign src_read      = (st_q.sync_cnt != 3'h0) ? csu_pkg::SRC_SYNCING : st_q.sys_sel;
	assign ref_edge      = st_q.ref_s & ~st_q.ref_p;
	assign tgt_edge      = st_q.tgt_s & ~st_q.tgt_p;
	assign mon_tick      = (st_q.div_cnt == MON_DIV - 8'h01);
	assign loc_evt       = mon_tick & st_q.osc.clk_mon_en & ~tgt_edge
	                     & (st_q.miss_cnt + 4'h1 == st_q.ref_loss_trip_point);

	always_comb begin
		lock_evt[0] = (st_q.mode_a == csu_pkg::EDGE_ANY  && (lock_rise[0] || lock_fall[0]))
		           || (st_q.mode_a == csu_pkg::EDGE_RISE && lock_rise[0])
		           || (st_q.mode_a == csu_pkg::EDGE_FALL && lock_fall[0]);
		lock_evt[1] = (st_q.mode_b == csu_pkg::EDGE_ANY  && (lock_rise[1] || lock_fall[1]))
		           || (st_q.mode_b == csu_pkg::EDGE_RISE && lock_rise[1])
		           || (st_q.mode_b == csu_pkg::EDGE_FALL && lock_fall[1]);
	end

	assign wr_ctrl = st_q.ap_wr && st_q.ap_addr == csu_pkg::CTRL_OFS;
	assign wr_div  = st_q.ap_wr && st_q.ap_addr == csu_pkg::DIVIDE_OFS;
	assign wr_stat = st_q.ap_wr && st_q.ap_addr == csu_pkg::STATUS_OFS;
	assign wr_osc  = st_q.ap_wr && st_q.ap_addr == csu_pkg::OSC_CTRL_OFS;
	assign wr_osc2 = st_q.ap_wr && st_q.ap_addr == csu_pkg::OSC_CTRL2_OFS;
	assign wr_chk  = st_q.ap_wr && st_q.ap_addr == csu_pkg::CHECK_OFS;
	assign rd_stat = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == csu_pkg::STATUS_OFS;

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_d = st_q;
		// Synchronisers and edge history
		st_d.lk_m  = lock_raw;
		st_d.lk_s  = st_q.lk_m;
		st_d.lk_p  = lock_ind;
		st_d.rdy_m = crystal_ok_raw;
		st_d.rdy_s = st_q.rdy_m;
		st_d.ref_m = ref_clk_raw;
		st_d.ref_s = st_q.ref_m;
		st_d.ref_p = st_q.ref_s;
		st_d.tgt_m = crystal_clk_raw;
		st_d.tgt_s = st_q.tgt_m;
		st_d.tgt_p = st_q.tgt_s;

		// Bus address phase
		st_d.ap_wr = 1'b0;
		if (hsel && hready && htrans[1]) begin
			st_d.ap_wr   = hwrite;
			st_d.ap_addr = haddr[7:0];
			case (haddr[7:0])
				csu_pkg::CTRL_OFS: begin
					st_d.rdata = {17'h0, st_q.pll.pwm_halve, st_q.osc.clk_mon_en, st_q.loc_ie,
					              st_q.mode_b, st_q.mode_a, st_q.pll.pll_pd, st_q.pll.lock_det_en,
					              st_q.pre_src, 2'h0, st_q.sys_src};
				end
				csu_pkg::DIVIDE_OFS: begin
					st_d.rdata = {12'h0, st_q.ref_loss_trip_point, st_q.pll.postscale, st_q.pll.prescale,
					              2'h0, st_q.pll.divide_by};
				end
				csu_pkg::STATUS_OFS: begin
					st_d.rdata = {21'h0, crystal_ready, src_read, 1'b0, st_q.pll.pll_pd,
					              lock_ind, 1'b0, st_q.loc, st_q.lock_loss};
				end
				csu_pkg::OSC_CTRL_OFS: begin
					st_d.rdata = {15'h0, st_q.osc.ext_halve, st_q.osc.ext_src_sel, st_q.osc.direct_clk,
					              st_q.osc.high_power, st_q.osc.rc_pd, st_q.osc.crystal_pd,
					              st_q.osc.relax_pd, st_q.osc.relax_trim};
				end
				csu_pkg::OSC_CTRL2_OFS: st_d.rdata = {23'h0, st_q.osc.rc_retrim};
				csu_pkg::CHECK_OFS:     st_d.rdata = {31'h0, st_q.chk_en};
				csu_pkg::COUNTS_OFS:    st_d.rdata = {st_q.chk_tgt, st_q.chk_ref};
				default:                st_d.rdata = 32'h0;
			endcase
		end

		// Control register
		if (wr_ctrl) begin
			if (hwdata[1:0] <= csu_pkg::SRC_POSTSCALER && hwdata[1:0] != st_q.sys_src) begin
				st_d.sys_src  = hwdata[1:0];
				st_d.sync_cnt = csu_pkg::SYNC_CYCLES;
			end
			if (hwdata[5:4] != 2'h3) begin
				st_d.pre_src = hwdata[5:4];
			end
			st_d.pll.lock_det_en = hwdata[6];
			st_d.pll.pll_pd      = hwdata[7];
			if (st_q.mode_a == csu_pkg::EDGE_OFF || hwdata[9:8] == csu_pkg::EDGE_OFF) begin
				st_d.mode_a = hwdata[9:8];
			end
			if (st_q.mode_b == csu_pkg::EDGE_OFF || hwdata[11:10] == csu_pkg::EDGE_OFF) begin
				st_d.mode_b = hwdata[11:10];
			end
			st_d.loc_ie         = hwdata[12];
			st_d.osc.clk_mon_en = hwdata[13];
			st_d.pll.pwm_halve  = hwdata[14];
		end

		// Source switch synchronisation; PLL power-down forces master clock
		if (st_d.pll.pll_pd && st_d.sys_src != csu_pkg::SRC_MASTER_OSC) begin
			st_d.sys_src  = csu_pkg::SRC_MASTER_OSC;
			st_d.sync_cnt = csu_pkg::SYNC_CYCLES;
		end else if (!wr_ctrl && st_q.sync_cnt != 3'h0) begin
			st_d.sync_cnt = st_q.sync_cnt - 3'h1;
			if (st_q.sync_cnt == 3'h1) begin
				st_d.sys_sel = st_q.sys_src;
			end
		end

		// Divide-by register
		if (wr_div) begin
			st_d.pll.divide_by = hwdata[5:0];
			st_d.pll.prescale  = (hwdata[11:8] > csu_pkg::SCALE_MAX) ? csu_pkg::SCALE_MAX : hwdata[11:8];
			st_d.pll.postscale = (hwdata[15:12] > csu_pkg::SCALE_MAX) ? csu_pkg::SCALE_MAX : hwdata[15:12];
			st_d.ref_loss_trip_point = (hwdata[19:16] < csu_pkg::REF_LOSS_TRIP_POINT_MIN) ? csu_pkg::REF_LOSS_TRIP_POINT_MIN : hwdata[19:16];
		end

		// Oscillator control registers
		if (wr_osc) begin
			st_d.osc.relax_trim  = hwdata[9:0];
			st_d.osc.relax_pd    = hwdata[10];
			st_d.osc.crystal_pd  = hwdata[11];
			st_d.osc.rc_pd       = hwdata[12];
			st_d.osc.high_power  = hwdata[13];
			st_d.osc.direct_clk  = hwdata[14];
			st_d.osc.ext_src_sel = hwdata[15];
			if (st_q.pre_src != csu_pkg::PRE_CRYSTAL) begin
				st_d.osc.ext_halve = hwdata[16];
			end
		end
		if (wr_osc2) begin
			st_d.osc.rc_retrim = hwdata[8:0];
		end

		// Sticky flags, write one to clear, set wins
		st_d.lock_loss = (st_q.lock_loss & ~({2{wr_stat}} & hwdata[1:0])) | lock_evt;
		st_d.loc       = (st_q.loc & ~(wr_stat & hwdata[2])) | loc_evt;

		// Loss-of-clock monitor
		st_d.div_cnt = mon_tick ? '0 : st_q.div_cnt + 8'h01;
		if (!st_q.osc.clk_mon_en || tgt_edge) begin
			st_d.miss_cnt = 4'h0;
		end else if (mon_tick && st_q.miss_cnt != 4'hF) begin
			st_d.miss_cnt = st_q.miss_cnt + 4'h1;
		end

		// Clock checking
		if (wr_chk) begin
			st_d.chk_en = hwdata[0];
			if (hwdata[0]) begin
				st_d.chk_ref = '0;
				st_d.chk_tgt = '0;
			end
		end else if (st_q.chk_en) begin
			if (ref_edge) begin
				st_d.chk_ref = st_q.chk_ref + 16'h0001;
				if (st_q.chk_ref == CHK_REF_LEN - 16'h0001) begin
					st_d.chk_en = 1'b0;
				end
			end
			if (tgt_edge && st_q.chk_tgt != 16'hFFFF) begin
				st_d.chk_tgt = st_q.chk_tgt + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q                <= '0;
			st_q.osc.relax_trim <= csu_pkg::RELAX_TRIM_RST;
			st_q.osc.rc_retrim  <= csu_pkg::RC_RETRIM_RST;
			st_q.osc.high_power <= 1'b1;
			st_q.ref_loss_trip_point          <= csu_pkg::REF_LOSS_TRIP_POINT_RST;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign hrdata                  = st_q.rdata;
	assign hreadyout               = 1'b1;
	assign hresp                   = 1'b0;
	assign sys_clk_x2_sel          = st_q.sys_sel;
	assign prescaler_source_select = st_q.pre_src;
	assign pll_cfg                 = st_q.pll;
	assign osc_cfg                 = st_q.osc;
	assign irq = |(st_q.lock_loss & {st_q.mode_b != csu_pkg::EDGE_OFF, st_q.mode_a != csu_pkg::EDGE_OFF})
	           | (st_q.loc & st_q.loc_ie);

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	src_sync_done_a: assert property (
		(st_q.sync_cnt == csu_pkg::SYNC_CYCLES && !st_q.pll.pll_pd && !wr_ctrl) ##1 !wr_ctrl [*3]
		|=> sys_clk_x2_sel == $past(st_q.sys_src, 4))
		else $error("source not applied after sync");
	src_read_a: assert property (rd_stat && st_q.sync_cnt != 3'h0 |=> hrdata[9:8] == csu_pkg::SRC_SYNCING)
		else $error("source readback not syncing");
	trim_write_a: assert property ($changed(osc_cfg.relax_trim) |-> $past(wr_osc))
		else $error("trim changed without write");
	flag_clear_a: assert property ($fell(st_q.lock_loss[0]) |-> $past(wr_stat && hwdata[0]))
		else $error("lock loss flag cleared without write");
	halve_guard_a: assert property ($changed(osc_cfg.ext_halve) |-> $past(st_q.pre_src != csu_pkg::PRE_CRYSTAL))
		else $error("halving changed while crystal selected");
	mode_lock_a: assert property ($changed(st_q.mode_a)
		|-> ($past(st_q.mode_a) == csu_pkg::EDGE_OFF || st_q.mode_a == csu_pkg::EDGE_OFF))
		else $error("edge mode changed while enabled");
	lock_gate_a: assert property ($rose(st_q.lock_loss[1]) |-> $past(pll_cfg.lock_det_en))
		else $error("lock loss without detector");
	crystal_ready_a: assert property (rd_stat && (osc_cfg.crystal_pd || !st_q.rdy_s) |=> !hrdata[10])
		else $error("crystal ready while disabled");
	check_done_a: assert property ($fell(st_q.chk_en) && !$past(wr_chk) |-> st_q.chk_ref == CHK_REF_LEN)
		else $error("check ended with wrong count");
	trip_range_a: assert property (st_q.ref_loss_trip_point >= csu_pkg::REF_LOSS_TRIP_POINT_MIN)
		else $error("trip point out of range");
	scale_range_a: assert property (pll_cfg.postscale <= csu_pkg::SCALE_MAX && pll_cfg.prescale <= csu_pkg::SCALE_MAX)
		else $error("scaler code out of range");
	loc_mon_a: assert property ($rose(st_q.loc) |-> $past(osc_cfg.clk_mon_en))
		else $error("loss of clock without monitor");
	irq_a: assert property (st_q.loc && st_q.loc_ie |-> irq)
		else $error("interrupt missing");
	lock_read_a: assert property (rd_stat && !pll_cfg.lock_det_en |=> hrdata[5:4] == 2'h0)
		else $error("lock shown without detector");
	pd_master_a: assert property (pll_cfg.pll_pd |-> st_q.sys_src == csu_pkg::SRC_MASTER_OSC)
		else $error("power-down left PLL source selected");
	sel_hold_a: assert property (st_q.sync_cnt > 3'h1 |=> $stable(sys_clk_x2_sel))
		else $error("source applied before sync ended");
	pre_legal_a: assert property (prescaler_source_select != 2'h3)
		else $error("illegal prescaler source");
	div_write_a: assert property ($changed(pll_cfg.divide_by) |-> $past(wr_div))
		else $error("divide-by changed without write");
	retrim_write_a: assert property ($changed(osc_cfg.rc_retrim) |-> $past(wr_osc2))
		else $error("retrim changed without write");
	loc_clear_a: assert property ($fell(st_q.loc) |-> $past(wr_stat && hwdata[2]))
		else $error("loss of clock cleared without write");
	check_start_a: assert property ($rose(st_q.chk_en) |-> st_q.chk_ref == '0 && st_q.chk_tgt == '0)
		else $error("check started with stale counts");
	irq_lock_a: assert property (st_q.lock_loss[0] && st_q.mode_a != csu_pkg::EDGE_OFF |-> irq)
		else $error("lock loss interrupt missing");

	switch_c: cover property (wr_ctrl ##1 st_q.sync_cnt != 3'h0 ##[1:8] sys_clk_x2_sel == csu_pkg::SRC_POSTSCALER);
	check_c: cover property ($fell(st_q.chk_en) && !$past(wr_chk));
	loc_c: cover property ($rose(st_q.loc) ##[1:20] !st_q.loc);
	lock_c: cover property ($rose(st_q.lock_loss[0]) && st_q.mode_a == csu_pkg::EDGE_ANY);
	halve_c: cover property (wr_osc && st_q.pre_src == csu_pkg::PRE_CRYSTAL);

endmodule // csu_ctrl

// *** hw/csu_pkg.sv ***
package csu_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] DIVIDE_OFS    = 8'h04;
	localparam logic [7:0] STATUS_OFS    = 8'h08;
	localparam logic [7:0] OSC_CTRL_OFS  = 8'h0C;
	localparam logic [7:0] OSC_CTRL2_OFS = 8'h10;
	localparam logic [7:0] CHECK_OFS     = 8'h14;
	localparam logic [7:0] COUNTS_OFS    = 8'h18;

	////////////////////////////////////////////////////////////////////////////
	// Encodings
	localparam logic [1:0] SRC_MASTER_OSC = 2'h0;
	localparam logic [1:0] SRC_POSTSCALER = 2'h1;
	localparam logic [1:0] SRC_SYNCING    = 2'h3;
	localparam logic [1:0] PRE_RELAX      = 2'h0;
	localparam logic [1:0] PRE_CRYSTAL    = 2'h1;
	localparam logic [1:0] PRE_RC         = 2'h2;
	localparam logic [1:0] EDGE_OFF       = 2'h0;
	localparam logic [1:0] EDGE_RISE      = 2'h1;
	localparam logic [1:0] EDGE_FALL      = 2'h2;
	localparam logic [1:0] EDGE_ANY       = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// Reset values, limits and timing counts
	localparam logic [9:0] RELAX_TRIM_RST = 10'h200;
	localparam logic [8:0] RC_RETRIM_RST  = 9'h100;
	localparam logic [3:0] REF_LOSS_TRIP_POINT_RST      = 4'h2;
	localparam logic [3:0] REF_LOSS_TRIP_POINT_MIN      = 4'h1;
	localparam logic [3:0] SCALE_MAX      = 4'h8;
	localparam logic [2:0] SYNC_CYCLES    = 3'h4;
	localparam int         MON_DIV_W      = 8;
	localparam int         CNT_W          = 16;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [5:0] divide_by;
		logic [3:0] prescale;
		logic [3:0] postscale;
		logic       lock_det_en;
		logic       pll_pd;
		logic       pwm_halve;
	} csu_pll_cfg_t;

	typedef struct packed {
		logic [9:0] relax_trim;
		logic       relax_pd;
		logic       crystal_pd;
		logic       rc_pd;
		logic       high_power;
		logic       direct_clk;
		logic       ext_src_sel;
		logic       ext_halve;
		logic       clk_mon_en;
		logic [8:0] rc_retrim;
	} csu_osc_cfg_t;

	typedef struct packed {
		logic [1:0]           lk_m;
		logic [1:0]           lk_s;
		logic [1:0]           lk_p;
		logic                 rdy_m;
		logic                 rdy_s;
		logic                 ref_m;
		logic                 ref_s;
		logic                 ref_p;
		logic                 tgt_m;
		logic                 tgt_s;
		logic                 tgt_p;
		logic [1:0]           sys_src;
		logic [1:0]           sys_sel;
		logic [2:0]           sync_cnt;
		logic [1:0]           pre_src;
		logic [1:0]           mode_a;
		logic [1:0]           mode_b;
		logic                 loc_ie;
		csu_pll_cfg_t         pll;
		csu_osc_cfg_t         osc;
		logic [1:0]           lock_loss;
		logic                 loc;
		logic [3:0]           ref_loss_trip_point;
		logic [3:0]           miss_cnt;
		logic [MON_DIV_W-1:0] div_cnt;
		logic                 chk_en;
		logic [CNT_W-1:0]     chk_ref;
		logic [CNT_W-1:0]     chk_tgt;
		logic                 ap_wr;
		logic [7:0]           ap_addr;
		logic [31:0]          rdata;
	} csu_state_t;

endpackage

// *** tb/csu_osc_model.sv ***
`timescale 1ns/1ps
module csu_osc_model (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  csu_pkg::csu_pll_cfg_t pll_cfg,
	input  csu_pkg::csu_osc_cfg_t osc_cfg,
	input  wire logic [1:0]       lock_go,
	input  wire logic             crystal_run,
	output logic      [1:0]       lock_raw,
	output logic                  crystal_ok_raw,
	output logic                  ref_clk_raw,
	output logic                  crystal_clk_raw
);
	logic [2:0] cnt_q;
	logic [1:0] ref_q;
	logic       xrun;
	////////////////////////////////////////////////////////////////////////////
	// Crystal runs only when powered and started
	assign xrun = crystal_run & ~osc_cfg.crystal_pd;
	assign crystal_ok_raw = xrun;
	// PLL locks only while powered
	assign lock_raw = lock_go & {2{~pll_cfg.pll_pd}};
	assign crystal_clk_raw = xrun & cnt_q[2];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 3'h0;
			ref_q <= 2'h0;
			ref_clk_raw <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			ref_q <= (ref_q == 2'h2) ? 2'h0 : ref_q + 2'h1;
			if (ref_q == 2'h2) begin
				ref_clk_raw <= ~ref_clk_raw;
			end
		end
	end
endmodule // csu_osc_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
	logic                  hclk;
	logic                  hresetn;
	logic                  hsel;
	logic [31:0]           haddr;
	logic [1:0]            htrans;
	logic                  hwrite;
	logic [2:0]            hsize;
	logic [31:0]           hwdata;
	logic [31:0]           hrdata;
	logic                  hreadyout;
	logic                  hresp;
	logic [1:0]            lock_raw;
	logic                  crystal_ok_raw;
	logic                  ref_clk_raw;
	logic                  crystal_clk_raw;
	logic [1:0]            sys_clk_x2_sel;
	logic [1:0]            prescaler_source_select;
	csu_pkg::csu_pll_cfg_t pll_cfg;
	csu_pkg::csu_osc_cfg_t osc_cfg;
	logic                  irq;
	logic [1:0]            lock_go;
	logic                  crystal_run;
	logic [31:0]           rd;
	int                    num_errors;
	int                    cmp_count;
	int                    cyc = 0;
	csu_ctrl #(.CHK_REF_LEN(16'h0008), .MON_DIV(8'h04)) u_csu_ctrl (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .lock_raw(lock_raw), .crystal_ok_raw(crystal_ok_raw), .ref_clk_raw(ref_clk_raw),
		.crystal_clk_raw(crystal_clk_raw), .sys_clk_x2_sel(sys_clk_x2_sel),
		.prescaler_source_select(prescaler_source_select), .pll_cfg(pll_cfg), .osc_cfg(osc_cfg), .irq(irq));
	csu_osc_model u_csu_osc_model (
		.hclk(hclk), .hresetn(hresetn), .pll_cfg(pll_cfg), .osc_cfg(osc_cfg), .lock_go(lock_go),
		.crystal_run(crystal_run), .lock_raw(lock_raw), .crystal_ok_raw(crystal_ok_raw),
		.ref_clk_raw(ref_clk_raw), .crystal_clk_raw(crystal_clk_raw));
	////////////////////////////////////////////////////////////////////////////
	// Bus tasks and compare
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= 1'b1;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0; hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		// Let the write land before ports are compared
		#1;
	endtask
	task automatic rdr(input logic [7:0] a);
		hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= 1'b0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rdr(csu_pkg::OSC_CTRL_OFS); chk(rd, 32'h0000_2200, "osc ctrl reset");
		rdr(csu_pkg::OSC_CTRL2_OFS); chk(rd, 32'h0000_0100, "retrim reset");
		rdr(csu_pkg::DIVIDE_OFS); chk(rd, 32'h0002_0000, "divide reset");
		rdr(8'h1C); chk(rd, 32'h0, "unmapped read");
		chk({30'h0, sys_clk_x2_sel}, 32'h0, "source reset");
		chk({30'h0, hresp, hreadyout}, 32'h1, "okay response");
		$display("test reset done");
	endtask
	task automatic t_osc();
		wr(csu_pkg::OSC_CTRL_OFS, 32'h0000_C3FF);
		wr(csu_pkg::OSC_CTRL2_OFS, 32'h0000_01FF);
		rdr(csu_pkg::OSC_CTRL_OFS); chk(rd, 32'h0000_C3FF, "osc ctrl rb");
		chk({22'h0, osc_cfg.relax_trim}, 32'h3FF, "trim port");
		chk({29'h0, osc_cfg.direct_clk, osc_cfg.ext_src_sel, osc_cfg.high_power}, 32'h6, "osc bits");
		chk({23'h0, osc_cfg.rc_retrim}, 32'h1FF, "retrim port");
		$display("test osc done");
	endtask
	task automatic t_halve();
		wr(csu_pkg::CTRL_OFS, 32'h0000_0010);
		chk({30'h0, prescaler_source_select}, 32'h1, "prescaler port");
		wr(csu_pkg::OSC_CTRL_OFS, 32'h0001_C7FF);
		rdr(csu_pkg::OSC_CTRL_OFS); chk(rd, 32'h0000_C7FF, "halve refused");
		wr(csu_pkg::OSC_CTRL_OFS, 32'h0000_C3FF);
		wr(csu_pkg::CTRL_OFS, 32'h0000_0000);
		wr(csu_pkg::OSC_CTRL_OFS, 32'h0001_C3FF);
		rdr(csu_pkg::OSC_CTRL_OFS); chk(rd, 32'h0001_C3FF, "halve taken");
		chk({31'h0, osc_cfg.ext_halve}, 32'h1, "halve port");
		wr(csu_pkg::CTRL_OFS, 32'h0000_0020);
		wr(csu_pkg::CTRL_OFS, 32'h0000_0030);
		chk({30'h0, prescaler_source_select}, 32'h2, "prescaler code 3 refused");
		wr(csu_pkg::CTRL_OFS, 32'h0000_0000);
		$display("test halve done");
	endtask
	task automatic t_divide();
		wr(csu_pkg::DIVIDE_OFS, 32'h0000_983F);
		rdr(csu_pkg::DIVIDE_OFS); chk(rd, 32'h0001_883F, "divide clamp");
		chk({26'h0, pll_cfg.divide_by}, 32'h3F, "divide port");
		chk({24'h0, pll_cfg.prescale, pll_cfg.postscale}, 32'h88, "scaler port");
		$display("test divide done");
	endtask
	task automatic t_switch();
		wr(csu_pkg::CTRL_OFS, 32'h0000_0041);
		rdr(csu_pkg::STATUS_OFS); chk({30'h0, rd[9:8]}, 32'h3, "syncing code");
		repeat (8) @(posedge hclk);
		chk({30'h0, sys_clk_x2_sel}, 32'h1, "postscaler applied");
		wr(csu_pkg::CTRL_OFS, 32'h0000_0042);
		repeat (8) @(posedge hclk);
		rdr(csu_pkg::STATUS_OFS); chk({30'h0, rd[9:8]}, 32'h1, "bad source ignored");
		wr(csu_pkg::CTRL_OFS, 32'h0000_0081);
		repeat (8) @(posedge hclk);
		rdr(csu_pkg::STATUS_OFS); chk({29'h0, rd[6], rd[9:8]}, 32'h4, "pd forces master");
		chk({30'h0, sys_clk_x2_sel}, 32'h0, "master applied");
		$display("test switch done");
	endtask
	task automatic t_lock();
		wr(csu_pkg::CTRL_OFS, 32'h0000_0640);
		repeat (6) @(posedge hclk);
		rdr(csu_pkg::STATUS_OFS); chk({30'h0, rd[5:4]}, 32'h1, "lock status");
		wr(csu_pkg::CTRL_OFS, 32'h0000_0540);
		rdr(csu_pkg::CTRL_OFS); chk({30'h0, rd[9:8]}, 32'h2, "mode kept");
		lock_go <= 2'h2;
		repeat (6) @(posedge hclk);
		rdr(csu_pkg::STATUS_OFS); chk({30'h0, rd[1:0]}, 32'h3, "lock loss flags");
		chk({31'h0, irq}, 32'h1, "lock irq");
		wr(csu_pkg::STATUS_OFS, 32'h0000_0001);
		rdr(csu_pkg::STATUS_OFS); chk({30'h0, rd[1:0]}, 32'h2, "clear a only");
		wr(csu_pkg::STATUS_OFS, 32'h0000_0002);
		@(posedge hclk); chk({31'h0, irq}, 32'h0, "irq cleared");
		wr(csu_pkg::CTRL_OFS, 32'h0000_0040);
		wr(csu_pkg::CTRL_OFS, 32'h0000_0340);
		rdr(csu_pkg::CTRL_OFS);
		chk({30'h0, rd[9:8]}, 32'h3, "mode after disable");
		lock_go <= 2'h3;
		repeat (6) @(posedge hclk);
		rdr(csu_pkg::STATUS_OFS);
		chk({30'h0, rd[1:0]}, 32'h1, "any edge flag");
		wr(csu_pkg::STATUS_OFS, 32'h0000_0001);
		$display("test lock done");
	endtask
	task automatic t_loc();
		wr(csu_pkg::DIVIDE_OFS, 32'h0003_883F);
		rdr(csu_pkg::DIVIDE_OFS);
		chk({28'h0, rd[19:16]}, 32'h3, "trip point kept");
		rdr(csu_pkg::STATUS_OFS); chk({31'h0, rd[10]}, 32'h1, "crystal ready");
		wr(csu_pkg::CTRL_OFS, 32'h0000_7000);
		chk({31'h0, pll_cfg.pwm_halve}, 32'h1, "pwm halve");
		repeat (40) @(posedge hclk);
		chk({31'h0, irq}, 32'h0, "no loss while running");
		crystal_run <= 1'b0;
		for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge hclk);
		rdr(csu_pkg::STATUS_OFS); chk({29'h0, rd[10], rd[2], irq}, 32'h3, "loss of clock");
		wr(csu_pkg::STATUS_OFS, 32'h0000_0004);
		@(posedge hclk); chk({31'h0, irq}, 32'h0, "loc cleared");
		crystal_run <= 1'b1;
		$display("test loc done");
	endtask
	task automatic t_check();
		wr(csu_pkg::CHECK_OFS, 32'h0000_0001);
		rd = 32'h1;
		for (int i = 0; i < 100 && rd[0] !== 1'b0; i++) rdr(csu_pkg::CHECK_OFS);
		chk(rd, 32'h0, "check self clears");
		rdr(csu_pkg::COUNTS_OFS); chk({16'h0, rd[15:0]}, 32'h8, "ref count");
		chk({31'h0, rd[31:16] != 16'h0}, 32'h1, "target counted");
		$display("test check done");
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Clock, timeout, main
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	initial begin
		num_errors = 0; cmp_count = 0;
		hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = 32'h0; lock_go = 2'h1; crystal_run = 1'b1;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset(); t_osc(); t_halve(); t_divide(); t_switch(); t_lock(); t_loc(); t_check();
		finish_test();
	end
endmodule // tb
